// [core/mmtc_irq_flag.sv]
// sticky interrupt request flag for the timer channel.
// assumes set and clear are single-cycle strobes in the pclk domain.
`timescale 1ns/1ps
module mmtc_irq_flag (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // strobes
    input  wire logic hw_set,
    input  wire logic sw_clr,
    // flag
    output logic      flag
);

    logic flag_r;

    // set beats clear so a same-cycle event is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 1'b0;
        end else if (hw_set) begin
            flag_r <= 1'b1;              // see [R14]
        end else if (sw_clr) begin
            flag_r <= 1'b0;              // see [R14]
        end
    end

    assign flag = flag_r;

endmodule // mmtc_irq_flag

// [core/mmtc_prescaler.sv]
// count source divider for the timer channel.
// assumes enable is low whenever the sequencer is idle; an armed one-shot keeps it high.
`timescale 1ns/1ps
module mmtc_prescaler
    import mmtc_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       enable,
    input  wire logic [1:0] psc_sel,
    // count source
    output logic            tick
);

    logic [4:0] div_m1;
    logic [4:0] psc_r;

    // ratio lookup
    always_comb begin
        case (psc_sel)
            2'h0:    div_m1 = MMTC_DIV1_M1;
            2'h1:    div_m1 = MMTC_DIV2_M1;
            2'h2:    div_m1 = MMTC_DIV8_M1;
            default: div_m1 = MMTC_DIV32_M1;
        endcase
    end

    // restarts while enable is low so the first period after enable rises is whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_r <= MMTC_PSC_RST;
        end else if (!enable || psc_r >= div_m1) begin
            psc_r <= MMTC_PSC_RST;
        end else begin
            psc_r <= psc_r + 5'h01;
        end
    end

    assign tick = enable && (psc_r >= div_m1);

endmodule // mmtc_prescaler

// [core/mmtc_timer.sv]
// one 16-bit timer channel: timer, event counter, one-shot and pwm modes,
// with an apb register slave. assumes apb signals and event_in are
// synchronous to pclk; zero wait states.
`timescale 1ns/1ps

// Overview of operation
// [R1] In timer mode a count read returns the live counter value.
// [R2] In timer mode a read at the reload instant returns all ones.
// [R3] In event mode a reload read gives ones on underflow, zeros on overflow.
// [R4] Reads after a halted count write return it until restart.
// [R5] Software rewrites the count after halting a free-run event counter.
// [R6] Stopping a one-shot count halts it and reloads the counter.
// [R7] Stopping a one-shot count drives the pin low and sets the request flag.
// [R8] Picking one-shot after reset or from timer or event mode sets the flag.
// [R9] Picking pwm after reset or from timer or event mode sets the flag.
// [R10] Software writes zero to the flag after those mode selections.
// [R11] Clearing the start flag during pwm output stops the counter.
// [R12] Stopping pwm with the pin high drives it low and sets the flag.
// [R13] Stopping pwm with the pin low leaves pin and flag untouched.
// [R14] The request flag stays set until software writes zero to it.
module mmtc_timer
    import mmtc_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // event counter source
    input  wire logic        event_in,
    // timer output and request flag
    output logic             timer_output_pin,
    output logic             irq_request
);

    mmtc_ctrl_t   ctrl_r;
    mmtc_ctrl_t   ctrl_new;
    mmtc_state_t  state_r;
    mmtc_state_t  state_nxt;
    logic [15:0]  cnt_r;
    logic [15:0]  cnt_nxt;
    logic [15:0]  reload_r;
    logic [15:0]  rd_cnt;
    logic         pin_r;
    logic         pin_nxt;
    logic [31:0]  prdata_r;
    logic         pslverr_r;
    logic         ev_d_r;
    logic         ev_edge;
    logic         psc_tick;
    logic         tick;
    logic         setup;
    logic         wr_acc;
    logic         hit_ctrl;
    logic         hit_count;
    logic         hit_status;
    logic         ctrl_wr;
    logic         count_wr;
    logic         status_clr;
    logic         start_rise;
    logic         start_fall;
    logic         trig;
    logic         mode_set;
    logic         fsm_set;
    logic         reload_evt;
    logic         halted;
    logic         irq_q;

    // address decode and strobes
    assign setup      = psel && !penable;
    assign wr_acc     = psel && penable && pwrite;
    assign hit_ctrl   = (paddr == MMTC_OFF_CTRL);
    assign hit_count  = (paddr == MMTC_OFF_COUNT);
    assign hit_status = (paddr == MMTC_OFF_STATUS);
    assign ctrl_wr    = wr_acc && hit_ctrl;
    assign count_wr   = wr_acc && hit_count;
    assign ctrl_new   = mmtc_ctrl_t'(pwdata[MMTC_CTRL_W-1:0]);
    assign trig       = ctrl_wr && pwdata[MMTC_CTRL_TRIG_BIT];
    assign start_rise = ctrl_wr && !ctrl_r.start && ctrl_new.start;
    assign start_fall = ctrl_wr && ctrl_r.start && !ctrl_new.start;
    assign status_clr = wr_acc && hit_status && !pwdata[MMTC_STAT_IRQ_BIT];

    // spurious request on entry to one-shot or pwm from timer or event mode; reset mode is timer,
    // so the first selection after reset is covered by the same test
    assign mode_set = ctrl_wr            // see [R8] see [R9]
        && (ctrl_new.mode == MMTC_ONESHOT || ctrl_new.mode == MMTC_PWM)
        && (ctrl_r.mode == MMTC_TIMER || ctrl_r.mode == MMTC_EVENT);

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= mmtc_ctrl_t'(MMTC_CTRL_RST);
        end else if (ctrl_wr) begin
            ctrl_r <= ctrl_new;
        end
    end

    // reload register follows every count write, running or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_r <= MMTC_RELOAD_RST;
        end else if (count_wr) begin
            reload_r <= pwdata[15:0];
        end
    end

    // event source edge, input already in the pclk domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_d_r <= 1'b0;
        end else begin
            ev_d_r <= event_in;
        end
    end

    assign ev_edge = event_in && !ev_d_r;

    // count source: external edges in event mode, divided clock otherwise
    mmtc_prescaler u_psc (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (state_r != MMTC_ST_IDLE),
        .psc_sel (ctrl_r.psc),
        .tick    (psc_tick)
    );

    assign tick = (ctrl_r.mode == MMTC_EVENT) ? ev_edge : psc_tick;
    assign halted = (state_r == MMTC_ST_IDLE) || (state_r == MMTC_ST_OS_ARM);

    // reload instant of a running timer or event counter
    always_comb begin
        reload_evt = 1'b0;
        if (state_r == MMTC_ST_RUN && tick) begin
            if (ctrl_r.mode == MMTC_EVENT) begin
                reload_evt = ctrl_r.count_up ? (cnt_r == MMTC_CNT_ONES)
                                             : (cnt_r == MMTC_CNT_ZEROS);
            end else begin
                reload_evt = (cnt_r == MMTC_CNT_ZEROS);
            end
        end
    end

    // count read value; the counter itself is live otherwise
    always_comb begin
        rd_cnt = cnt_r;                  // see [R1] see [R4]
        if (reload_evt) begin
            if (ctrl_r.mode == MMTC_EVENT && ctrl_r.count_up) begin
                rd_cnt = MMTC_CNT_ZEROS; // see [R3]
            end else begin
                rd_cnt = MMTC_CNT_ONES;  // see [R2] see [R3]
            end
        end
    end

    // sequencer: software stop first, then start, then counting
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        pin_nxt   = pin_r;
        fsm_set   = 1'b0;
        if (start_fall) begin
            state_nxt = MMTC_ST_IDLE;    // see [R11]
            case (state_r)
                MMTC_ST_OS_RUN: begin
                    cnt_nxt = reload_r;  // see [R6]
                    pin_nxt = 1'b0;      // see [R7]
                    fsm_set = 1'b1;      // see [R7]
                end
                MMTC_ST_PWM_HI: begin
                    pin_nxt = 1'b0;      // see [R12]
                    fsm_set = 1'b1;      // see [R12]
                end
                default: begin
                    pin_nxt = pin_r;     // see [R13]
                end
            endcase
        end else if (start_rise) begin
            case (ctrl_new.mode)
                MMTC_ONESHOT: begin
                    if (trig) begin
                        state_nxt = MMTC_ST_OS_RUN;
                        cnt_nxt   = reload_r;
                        pin_nxt   = 1'b1;
                    end else begin
                        state_nxt = MMTC_ST_OS_ARM;
                    end
                end
                MMTC_PWM: begin
                    state_nxt = MMTC_ST_PWM_HI;
                    cnt_nxt   = reload_r;
                    pin_nxt   = 1'b1;
                end
                default: begin
                    state_nxt = MMTC_ST_RUN;
                end
            endcase
        end else begin
            case (state_r)
                MMTC_ST_RUN: begin
                    if (tick) begin
                        if (ctrl_r.mode == MMTC_EVENT && ctrl_r.count_up) begin
                            if (reload_evt) begin
                                fsm_set = 1'b1;
                                cnt_nxt = ctrl_r.free_run ? MMTC_CNT_ZEROS
                                                          : reload_r;
                            end else begin
                                cnt_nxt = cnt_r + 16'h0001;
                            end
                        end else if (reload_evt) begin
                            fsm_set = 1'b1;
                            cnt_nxt = (ctrl_r.mode == MMTC_EVENT
                                       && ctrl_r.free_run) ? MMTC_CNT_ONES
                                                           : reload_r;
                        end else begin
                            cnt_nxt = cnt_r - 16'h0001;
                        end
                    end
                end
                MMTC_ST_OS_ARM: begin
                    if (trig) begin
                        state_nxt = MMTC_ST_OS_RUN;
                        cnt_nxt   = reload_r;
                        pin_nxt   = 1'b1;
                    end
                end
                MMTC_ST_OS_RUN: begin
                    if (tick) begin
                        if (cnt_r == MMTC_CNT_ZEROS) begin
                            state_nxt = MMTC_ST_OS_ARM;
                            cnt_nxt   = reload_r;
                            pin_nxt   = 1'b0;
                            fsm_set   = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r - 16'h0001;
                        end
                    end
                end
                MMTC_ST_PWM_HI: begin
                    if (tick) begin
                        if (cnt_r == MMTC_CNT_ZEROS) begin
                            state_nxt = MMTC_ST_PWM_LO;
                            cnt_nxt   = ~reload_r;
                            pin_nxt   = 1'b0;
                            fsm_set   = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r - 16'h0001;
                        end
                    end
                end
                MMTC_ST_PWM_LO: begin
                    if (tick) begin
                        if (cnt_r == MMTC_CNT_ZEROS) begin
                            state_nxt = MMTC_ST_PWM_HI;
                            cnt_nxt   = reload_r;
                            pin_nxt   = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r - 16'h0001;
                        end
                    end
                end
                default: begin
                    state_nxt = MMTC_ST_IDLE;
                end
            endcase
            // halted counter takes a written value directly
            if (count_wr && halted) begin
                cnt_nxt = pwdata[15:0];  // see [R4]
            end
        end
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= MMTC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // counter; a free-run halt leaves it stale for software to rewrite
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= MMTC_CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // output pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    // request flag; software must clear it after a spurious set
    mmtc_irq_flag u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .hw_set  (fsm_set || mode_set),  // see [R14]
        .sw_clr  (status_clr),
        .flag    (irq_q)
    );

    // read data captured in setup so it is stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !(hit_ctrl || hit_count || hit_status);
            if (hit_ctrl) begin
                prdata_r <= {25'h0, ctrl_r};
            end else if (hit_count) begin
                prdata_r <= {16'h0, rd_cnt};
            end else if (hit_status) begin
                prdata_r <= {30'h0, pin_r, irq_q};
            end else begin
                prdata_r <= 32'h0;
            end
        end
    end

    // outputs
    assign pready           = 1'b1;
    assign prdata           = prdata_r;
    assign pslverr          = pslverr_r && psel && penable;
    assign timer_output_pin = pin_r;
    assign irq_request      = irq_q;

endmodule // mmtc_timer

// [include/mmtc_pkg.sv]
// package for the multi mode timer channel: register map, field layout,
// mode codes, sequencer states and the control word carrier.
// assumes a 32-bit apb register bus and a 16-bit counter.
package mmtc_pkg;

    // register byte offsets
    localparam logic [11:0] MMTC_OFF_CTRL   = 12'h000;
    localparam logic [11:0] MMTC_OFF_COUNT  = 12'h004;
    localparam logic [11:0] MMTC_OFF_STATUS = 12'h008;

    // control register field positions
    localparam int MMTC_CTRL_START_BIT = 0;
    localparam int MMTC_CTRL_MODE_LSB  = 1;
    localparam int MMTC_CTRL_UP_BIT    = 3;
    localparam int MMTC_CTRL_FREE_BIT  = 4;
    localparam int MMTC_CTRL_PSC_LSB   = 5;
    localparam int MMTC_CTRL_W         = 7;
    localparam int MMTC_CTRL_TRIG_BIT  = 7;

    // status register field positions
    localparam int MMTC_STAT_IRQ_BIT = 0;
    localparam int MMTC_STAT_PIN_BIT = 1;

    // reset values and fixed counter words
    localparam logic [6:0]  MMTC_CTRL_RST   = 7'h00;
    localparam logic [15:0] MMTC_CNT_RST    = 16'h0000;
    localparam logic [15:0] MMTC_RELOAD_RST = 16'h0000;
    localparam logic [15:0] MMTC_CNT_ONES   = 16'hFFFF;
    localparam logic [15:0] MMTC_CNT_ZEROS  = 16'h0000;

    // prescaler divide ratios, minus one
    localparam logic [4:0] MMTC_DIV1_M1  = 5'h00;
    localparam logic [4:0] MMTC_DIV2_M1  = 5'h01;
    localparam logic [4:0] MMTC_DIV8_M1  = 5'h07;
    localparam logic [4:0] MMTC_DIV32_M1 = 5'h1F;
    localparam logic [4:0] MMTC_PSC_RST  = 5'h00;

    // operating modes
    typedef enum logic [1:0] {
        MMTC_TIMER   = 2'h0,
        MMTC_EVENT   = 2'h1,
        MMTC_ONESHOT = 2'h2,
        MMTC_PWM     = 2'h3
    } mmtc_mode_t;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        MMTC_ST_IDLE   = 6'h01,
        MMTC_ST_RUN    = 6'h02,
        MMTC_ST_OS_ARM = 6'h04,
        MMTC_ST_OS_RUN = 6'h08,
        MMTC_ST_PWM_HI = 6'h10,
        MMTC_ST_PWM_LO = 6'h20
    } mmtc_state_t;

    // control word as stored, msb first
    typedef struct packed {
        logic [1:0] psc;
        logic       free_run;
        logic       count_up;
        mmtc_mode_t mode;
        logic       start;
    } mmtc_ctrl_t;

endpackage

// [tb/mmtc_timer_props.sv]
// timer channel checker on the top ports.
// assumes the package register map.
`timescale 1ns/1ps
module mmtc_timer_props
    import mmtc_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // outputs
    input wire logic        timer_output_pin,
    input wire logic        irq_request
);
    logic        acc;
    logic        wr_ctl;
    logic        wr_cnt;
    logic        clr;
    logic        wst;
    logic [1:0]  wmd;
    mmtc_mode_t  md_r;
    logic        st_r;
    logic        ok_r;
    logic [15:0] cnt_r;

    // access-phase decode
    assign acc    = psel && penable && pwrite;
    assign wr_ctl = acc && paddr == MMTC_OFF_CTRL;
    assign wr_cnt = acc && paddr == MMTC_OFF_COUNT;
    assign clr    = acc && paddr == MMTC_OFF_STATUS && !pwdata[0];
    assign wmd    = pwdata[MMTC_CTRL_MODE_LSB +: 2];
    assign wst    = pwdata[MMTC_CTRL_START_BIT];

    // shadow of the control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md_r <= MMTC_TIMER;
            st_r <= 1'b0;
        end else if (wr_ctl) begin
            md_r <= mmtc_mode_t'(wmd);
            st_r <= wst;
        end
    end

    // count written while halted, trusted until the next start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ok_r  <= 1'b0;
            cnt_r <= MMTC_CNT_RST;
        end else if (wr_cnt && !st_r) begin
            ok_r  <= 1'b1;
            cnt_r <= pwdata[15:0];
        end else if (wr_ctl && wst) begin
            ok_r <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_flag_sticky: assert property (
        irq_request && !clr |=> irq_request)
        else $error("flag lost");
    a_oneshot_sel: assert property (
        wr_ctl && wmd == MMTC_ONESHOT && md_r inside {MMTC_TIMER, MMTC_EVENT}
        |-> ##[1:2] irq_request)
        else $error("one-shot select, no flag");
    a_pwm_sel: assert property (
        wr_ctl && wmd == MMTC_PWM && md_r inside {MMTC_TIMER, MMTC_EVENT}
        |-> ##[1:2] irq_request)
        else $error("pwm select, no flag");
    a_oneshot_stop: assert property (
        wr_ctl && md_r == MMTC_ONESHOT && wmd == MMTC_ONESHOT && st_r
        && !wst && timer_output_pin
        |=> !timer_output_pin ##[0:1] irq_request)
        else $error("one-shot stop failed");
    a_pwm_stop_hi: assert property (
        wr_ctl && md_r == MMTC_PWM && wmd == MMTC_PWM && st_r && !wst
        && timer_output_pin |=> !timer_output_pin ##[0:1] irq_request)
        else $error("pwm high stop failed");
    a_pwm_stop_lo: assert property (
        wr_ctl && md_r == MMTC_PWM && wmd == MMTC_PWM && st_r && !wst
        && !timer_output_pin && !irq_request
        |=> (!timer_output_pin && !irq_request) [*2])
        else $error("pwm low stop moved");
    a_halt_pin_hold: assert property (
        !st_r && !wr_ctl |=> $stable(timer_output_pin))
        else $error("pin moved while halted");
    a_halt_readback: assert property (
        psel && penable && !pwrite && paddr == MMTC_OFF_COUNT && ok_r
        && !st_r |-> prdata == {16'h0, cnt_r})
        else $error("halted read mismatch");

    c_oneshot_stop: cover property (wr_ctl && md_r == MMTC_ONESHOT && !wst);
    c_pwm_stop: cover property (wr_ctl && md_r == MMTC_PWM && st_r && !wst);
    c_fixed_read: cover property (psel && penable && prdata == 32'h0000FFFF);
endmodule // mmtc_timer_props

// [tb/mmtc_timer_tb.sv]
// timer channel bench: a row table, then hand tests.
// assumes any apb wait count; checker bound below.
`timescale 1ns/1ps
module mmtc_timer_tb
    import mmtc_pkg::*;
;
    typedef struct {
        mmtc_mode_t  from_m;
        mmtc_mode_t  to_m;
        logic        irq;
        logic [31:0] cnt;
    } mmtc_row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        event_in = 1'b0;
    logic        timer_output_pin;
    logic        irq_request;
    int          miscompares = 0;
    int          checked = 0;
    logic [31:0] rq;
    logic        re;
    logic [15:0] sv;
    mmtc_row_t   rows [6] = '{
        '{MMTC_TIMER, MMTC_ONESHOT, 1'b1, 32'h1234},
        '{MMTC_EVENT, MMTC_ONESHOT, 1'b1, 32'hFFFF0000},
        '{MMTC_TIMER, MMTC_PWM,     1'b1, 32'hFFFF},
        '{MMTC_EVENT, MMTC_PWM,     1'b1, 32'hABCD0001},
        '{MMTC_TIMER, MMTC_EVENT,   1'b0, 32'h8000},
        '{MMTC_EVENT, MMTC_TIMER,   1'b0, 32'hFF}};

    mmtc_timer u_dut (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .pready           (pready),
        .prdata           (prdata),
        .pslverr          (pslverr),
        .event_in         (event_in),
        .timer_output_pin (timer_output_pin),
        .irq_request      (irq_request)
    );

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // event edge every other cycle
    always @(posedge pclk) event_in <= presetn ? ~event_in : 1'b0;

    // hang guard, well past the cycles the tests use
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    task automatic complete_run();
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // flag shows a cycle late; look mid-cycle
    task automatic settle();
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic pin_flag(input string nm, input logic p, input logic f);
        chk(nm, {30'h0, timer_output_pin, irq_request}, {30'h0, p, f});
    endtask

    function automatic logic [31:0] cw(mmtc_mode_t m, logic s, logic t);
        cw = 32'h0;
        cw[MMTC_CTRL_START_BIT] = s;
        cw[MMTC_CTRL_MODE_LSB +: 2] = m;
        cw[MMTC_CTRL_TRIG_BIT] = t;
    endfunction

    // forty reads at varied spacing; at least one must land on the reload edge
    task automatic sweep(input logic [31:0] c, input logic [15:0] rl,
                         input logic [15:0] sp, input logic up);
        logic seen;
        logic ok;
        seen = 1'b0;
        wr(MMTC_OFF_COUNT, {16'h0, rl});
        wr(MMTC_OFF_CTRL, c);
        for (int k = 0; k < 40; k++) begin
            repeat (k % 7) @(posedge pclk);
            rd(MMTC_OFF_COUNT);
            ok = (rq[15:0] === sp) || (up ? rq[15:0] >= rl : rq[15:0] <= rl);
            seen = seen | (rq[15:0] === sp);
            chk("count range", {31'h0, ok}, 32'h1);
        end
        chk("reload read", {31'h0, seen}, 32'h1);
        wr(MMTC_OFF_CTRL, c & 32'hFFFF_FFFE);
    endtask

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // table rows
        foreach (rows[i]) begin
            wr(MMTC_OFF_CTRL, cw(rows[i].from_m, 1'b0, 1'b0));
            wr(MMTC_OFF_STATUS, 32'h0);
            wr(MMTC_OFF_CTRL, cw(rows[i].to_m, 1'b0, 1'b0));
            settle();
            rd(MMTC_OFF_STATUS);
            chk("mode flag", rq, {31'h0, rows[i].irq});
            wr(MMTC_OFF_COUNT, rows[i].cnt);
            rd(MMTC_OFF_COUNT);
            chk("halted count", rq, {16'h0, rows[i].cnt[15:0]});
        end
        // reset again; one-shot first
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(MMTC_OFF_STATUS);
        chk("status reset", rq, 32'h0);
        wr(MMTC_OFF_CTRL, cw(MMTC_ONESHOT, 1'b0, 1'b0));
        settle();
        pin_flag("reset select", 1'b0, 1'b1);
        repeat (10) @(posedge pclk);
        wr(MMTC_OFF_STATUS, 32'h1);
        settle();
        pin_flag("flag kept", 1'b0, 1'b1);
        wr(MMTC_OFF_STATUS, 32'h0);
        settle();
        pin_flag("flag cleared", 1'b0, 1'b0);
        // unmapped word
        rd(12'h00C);
        chk("unmapped read", {re, rq[30:0]}, 32'h8000_0000);
        wr(12'h00C, 32'hFFFF_FFFF);
        chk("unmapped write", {31'h0, re}, 32'h1);
        // one-shot stopped in mid-count
        wr(MMTC_OFF_COUNT, 32'h200);
        wr(MMTC_OFF_CTRL, cw(MMTC_ONESHOT, 1'b1, 1'b1));
        settle();
        pin_flag("oneshot run", 1'b1, 1'b0);
        wr(MMTC_OFF_CTRL, cw(MMTC_ONESHOT, 1'b0, 1'b0));
        settle();
        pin_flag("oneshot stop", 1'b0, 1'b1);
        rd(MMTC_OFF_COUNT);
        chk("oneshot reload", rq, 32'h200);
        // pwm stop, high then low
        wr(MMTC_OFF_COUNT, 32'h8);
        wr(MMTC_OFF_CTRL, cw(MMTC_PWM, 1'b0, 1'b0));
        wr(MMTC_OFF_STATUS, 32'h0);
        wr(MMTC_OFF_CTRL, cw(MMTC_PWM, 1'b1, 1'b0));
        settle();
        pin_flag("pwm high", 1'b1, 1'b0);
        wr(MMTC_OFF_CTRL, cw(MMTC_PWM, 1'b0, 1'b0));
        settle();
        pin_flag("pwm stop high", 1'b0, 1'b1);
        rd(MMTC_OFF_COUNT);
        sv = rq[15:0];
        repeat (5) @(posedge pclk);
        rd(MMTC_OFF_COUNT);
        chk("pwm halted", rq, {16'h0, sv});
        wr(MMTC_OFF_CTRL, cw(MMTC_PWM, 1'b1, 1'b0));
        repeat (40) @(posedge pclk);
        wr(MMTC_OFF_STATUS, 32'h0);
        settle();
        pin_flag("pwm low", 1'b0, 1'b0);
        wr(MMTC_OFF_CTRL, cw(MMTC_PWM, 1'b0, 1'b0));
        settle();
        pin_flag("pwm stop low", 1'b0, 1'b0);
        // live count: two reads three edges apart
        wr(MMTC_OFF_COUNT, 32'h100);
        wr(MMTC_OFF_CTRL, cw(MMTC_TIMER, 1'b1, 1'b0));
        rd(MMTC_OFF_COUNT);
        sv = rq[15:0];
        rd(MMTC_OFF_COUNT);
        chk("live count", {16'h0, sv - rq[15:0]}, 32'h3);
        wr(MMTC_OFF_CTRL, cw(MMTC_TIMER, 1'b0, 1'b0));
        // reload-edge reads: timer, event down, event up
        sweep(cw(MMTC_TIMER, 1'b1, 1'b0), 16'h0003, 16'hFFFF, 1'b0);
        sweep(cw(MMTC_EVENT, 1'b1, 1'b0), 16'h0002, 16'hFFFF, 1'b0);
        sweep(cw(MMTC_EVENT, 1'b1, 1'b0) | 32'h8, 16'hFFFD, 16'h0000, 1'b1);
        complete_run();
    end
endmodule // mmtc_timer_tb

bind mmtc_timer mmtc_timer_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .timer_output_pin(timer_output_pin), .irq_request(irq_request)
);
